// File: include/scr_pkg.sv
// Constants and types of the speculation control register bank
// What this block does
// - Writing 1 to reserved control bits 63:8 or 6:3 faults with code zero
// - Register writes hold younger dispatch until done, memory stays unserialized
// - Control bits: forwarding off 7, bypass off 2, isolation 1, restriction 0
// - Restriction stops older lower-mode branches steering higher-mode predictions
// - Lower mode is privilege 3 or guest; higher is 0-2 on the host
// - Clearing restriction may let older branch history steer predictions again
// - Every write of 1 to restriction opens a fresh isolation window
// - Restriction forces sibling isolation on shared-predictor parts
// - Same-mode capability: restriction blocks all prior branches in every mode
// - Restriction leaves returns alone but trims return entries beyond 32 on large-return parts
// - Sibling isolation keeps thread predictions apart; returns never shared
// - Bypass off returns load data only with no unresolved older store
// - Legacy register bypass bit also blocks loads passing older stores
// - Forwarding off or bypass off disables predictive store forwarding
// - Command register is write-only; reads or reserved ones fault
// - Command bit 0 raises a barrier against older indirect predictions
// - Always-on capability keeps lower-to-higher blocking with no rewrites
package scr_pkg;

	localparam logic [31:0] ADDR_CONTROL_REG = 32'h0000_0048;
	localparam logic [31:0] ADDR_COMMAND_REG = 32'h0000_0049;

	localparam int          NUM_FIELDS     = 4;
	localparam int          POS_RESTRICT   = 0;
	localparam int          POS_SIBLING    = 1;
	localparam int          POS_BYPASS_OFF = 2;
	localparam int          POS_FWD_OFF    = 7;
	localparam int          POS_BARRIER    = 0;
	localparam int          FIELD_POS [NUM_FIELDS] = '{0, 1, 2, 7};

	localparam int          IDX_RESTRICT   = 0;
	localparam int          IDX_SIBLING    = 1;
	localparam int          IDX_BYPASS_OFF = 2;
	localparam int          IDX_FWD_OFF    = 3;

	localparam logic [63:0] CTRL_RSVD_MASK = 64'hFFFF_FFFF_FFFF_FF78;
	localparam logic [63:0] CMD_RSVD_MASK  = 64'hFFFF_FFFF_FFFF_FFFE;
	localparam logic [NUM_FIELDS-1:0] CTRL_RESET = 4'h0;

	localparam logic [1:0]  PRIV_USER      = 2'h3;
	localparam int          RET_ARCH_DEPTH = 32;

	typedef enum {SCR_IDLE, SCR_DONE} scr_phase_type;

endpackage : scr_pkg

// File: include/scr_spec_if.sv
// Interface between the bank top, its access decoder and its policy logic
`timescale 1ns/1ps
interface scr_spec_if;
	logic                          req_valid;
	logic                          req_write;
	logic [31:0]                   req_addr;
	logic [63:0]                   req_wdata;
	logic                          hit_ctrl;
	logic                          hit_cmd;
	logic                          gp_fault;
	logic [scr_pkg::NUM_FIELDS-1:0] ctrl_bits;
	logic [1:0]                    current_privilege_level;
	logic                          guest_mode;
	logic                          cap_shared_pred;
	logic                          cap_same_mode;
	logic                          cap_always_on;
	logic                          legacy_bypass_off;
	logic                          eff_sibling;
	logic                          eff_lower_block;
	logic                          eff_cross_block;
	logic                          eff_bypass_block;
	logic                          eff_fwd_off;

	modport top (output req_valid, req_write, req_addr, req_wdata, ctrl_bits,
		current_privilege_level, guest_mode, cap_shared_pred, cap_same_mode, cap_always_on,
		legacy_bypass_off,
		input hit_ctrl, hit_cmd, gp_fault, eff_sibling, eff_lower_block, eff_cross_block,
		eff_bypass_block, eff_fwd_off);
	modport dec (input req_valid, req_write, req_addr, req_wdata,
		output hit_ctrl, hit_cmd, gp_fault);
	modport pol (input ctrl_bits, current_privilege_level, guest_mode, cap_shared_pred,
		cap_same_mode, cap_always_on, legacy_bypass_off,
		output eff_sibling, eff_lower_block, eff_cross_block, eff_bypass_block, eff_fwd_off);
endinterface : scr_spec_if

// File: hdl/scr_access_decode.sv
// Address match and fault check for model-register accesses
`timescale 1ns/1ps
module scr_access_decode
(
	scr_spec_if.dec bus
);
	logic ctrl_rsvd_set;
	logic cmd_rsvd_set;

	assign bus.hit_ctrl  = bus.req_valid && (bus.req_addr == scr_pkg::ADDR_CONTROL_REG);
	assign bus.hit_cmd   = bus.req_valid && (bus.req_addr == scr_pkg::ADDR_COMMAND_REG);
	assign ctrl_rsvd_set = |(bus.req_wdata & scr_pkg::CTRL_RSVD_MASK);
	assign cmd_rsvd_set  = |(bus.req_wdata & scr_pkg::CMD_RSVD_MASK);

	// Faulting accesses change no state
	assign bus.gp_fault = (bus.hit_ctrl && bus.req_write && ctrl_rsvd_set)
		|| (bus.hit_cmd && (!bus.req_write || cmd_rsvd_set));
endmodule : scr_access_decode

// File: hdl/scr_spec_policy.sv
// Effective speculation limits from stored control bits, mode and capabilities
`timescale 1ns/1ps
module scr_spec_policy
(
	scr_spec_if.pol ctl
);
	logic restrict_on;
	logic high_mode;

	assign restrict_on = ctl.ctrl_bits[scr_pkg::IDX_RESTRICT];
	// Privilege 0-2 on the host side is the higher prediction mode
	assign high_mode   = (ctl.current_privilege_level != scr_pkg::PRIV_USER)
		&& !ctl.guest_mode;

	assign ctl.eff_sibling = ctl.ctrl_bits[scr_pkg::IDX_SIBLING]
		|| (restrict_on && ctl.cap_shared_pred);
	// Continuous lower-to-higher blocking only where always-on is offered
	assign ctl.eff_lower_block = restrict_on && high_mode && ctl.cap_always_on;
	assign ctl.eff_cross_block = restrict_on && ctl.cap_same_mode;
	assign ctl.eff_bypass_block = ctl.ctrl_bits[scr_pkg::IDX_BYPASS_OFF]
		|| ctl.legacy_bypass_off;
	assign ctl.eff_fwd_off = ctl.ctrl_bits[scr_pkg::IDX_FWD_OFF]
		|| ctl.ctrl_bits[scr_pkg::IDX_BYPASS_OFF];
endmodule : scr_spec_policy

// File: hdl/scr_spec_regs.sv
// Speculation control register bank: access port, stored bits and control outputs
`timescale 1ns/1ps
module scr_spec_regs
(
	input  wire logic        core_clk,
	input  wire logic        nrst,
	// Model-register access from the core
	input  wire logic        msr_req,
	input  wire logic        msr_write,
	input  wire logic [31:0] msr_addr,
	input  wire logic [63:0] msr_wdata,
	output logic             msr_done,
	output logic             msr_gp_fault,
	output logic [63:0]      msr_rdata,
	output logic             dispatch_hold,
	// Core state and capability levels
	input  wire logic [1:0]  current_privilege_level,
	input  wire logic        guest_mode,
	input  wire logic        cap_shared_pred,
	input  wire logic        cap_same_mode,
	input  wire logic        cap_always_on,
	input  wire logic        cap_large_return,
	input  wire logic        legacy_bypass_off,
	// Controls toward predictors and load/store unit
	output logic             restrict_indirect,
	output logic             sibling_isolate,
	output logic             lower_to_higher_block,
	output logic             cross_mode_block,
	output logic             store_bypass_block,
	output logic             predictive_forwarding_off,
	output logic             indirect_window_flush,
	output logic             return_trim,
	output logic             indirect_prediction_barrier
);

	//--------------------------------------------------------------------
	// Sub-block wiring
	//--------------------------------------------------------------------
	scr_spec_if bus_if ();

	logic [scr_pkg::NUM_FIELDS-1:0] field_reg;
	scr_pkg::scr_phase_type         phase_reg;
	logic                           ctrl_wr_ok;
	logic                           cmd_wr_ok;
	logic                           restrict_wr_one;
	logic [63:0]                    ctrl_view;

	assign bus_if.req_valid         = msr_req;
	assign bus_if.req_write         = msr_write;
	assign bus_if.req_addr          = msr_addr;
	assign bus_if.req_wdata         = msr_wdata;
	assign bus_if.ctrl_bits         = field_reg;
	assign bus_if.current_privilege_level = current_privilege_level;
	assign bus_if.guest_mode        = guest_mode;
	assign bus_if.cap_shared_pred   = cap_shared_pred;
	assign bus_if.cap_same_mode     = cap_same_mode;
	assign bus_if.cap_always_on     = cap_always_on;
	assign bus_if.legacy_bypass_off = legacy_bypass_off;

	scr_access_decode u_decode
	(
		.bus (bus_if.dec)
	);

	scr_spec_policy u_policy
	(
		.ctl (bus_if.pol)
	);

	//--------------------------------------------------------------------
	// Access qualification
	//--------------------------------------------------------------------
	assign ctrl_wr_ok      = bus_if.hit_ctrl && msr_write && !bus_if.gp_fault;
	assign cmd_wr_ok       = bus_if.hit_cmd && msr_write && !bus_if.gp_fault;
	assign restrict_wr_one = ctrl_wr_ok && msr_wdata[scr_pkg::POS_RESTRICT];

	// Stored bits at their positions, all else zero
	always_comb
	begin
		ctrl_view = 64'h0000_0000_0000_0000;
		for (int i = 0; i < scr_pkg::NUM_FIELDS; i++)
		begin
			ctrl_view[scr_pkg::FIELD_POS[i]] = field_reg[i];
		end
	end

	//--------------------------------------------------------------------
	// Control fields, one flop per defined bit
	//--------------------------------------------------------------------
	generate
		for (genvar g = 0; g < scr_pkg::NUM_FIELDS; g++)
		begin : g_field
			always_ff @(posedge core_clk)
			begin
				if (!nrst)
					field_reg[g] <= scr_pkg::CTRL_RESET[g];
				else if (ctrl_wr_ok)
					field_reg[g] <= msr_wdata[scr_pkg::FIELD_POS[g]];
			end
		end
	endgenerate

	//--------------------------------------------------------------------
	// Access answer and dispatch hold
	//--------------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			phase_reg <= scr_pkg::SCR_IDLE;
		else
		begin
			case (phase_reg)
				scr_pkg::SCR_IDLE:
					if (bus_if.hit_ctrl || bus_if.hit_cmd)
						phase_reg <= scr_pkg::SCR_DONE;
				scr_pkg::SCR_DONE:
					if (!(bus_if.hit_ctrl || bus_if.hit_cmd))
						phase_reg <= scr_pkg::SCR_IDLE;
				default:
					phase_reg <= scr_pkg::SCR_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			msr_done     <= 1'b0;
			msr_gp_fault <= 1'b0;
		end
		else
		begin
			msr_done     <= bus_if.hit_ctrl || bus_if.hit_cmd;
			msr_gp_fault <= bus_if.gp_fault;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			msr_rdata <= 64'h0000_0000_0000_0000;
		else if (bus_if.hit_ctrl && !msr_write)
			msr_rdata <= ctrl_view;
		else
			msr_rdata <= 64'h0000_0000_0000_0000;
	end

	// Younger dispatch stalls while the write retires; no memory fence
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			dispatch_hold <= 1'b0;
		else
			dispatch_hold <= (bus_if.hit_ctrl || bus_if.hit_cmd) && msr_write;
	end

	//--------------------------------------------------------------------
	// Write-of-one events
	//--------------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			indirect_window_flush <= 1'b0;
			return_trim           <= 1'b0;
		end
		else
		begin
			// Fires even when the bit is already set
			indirect_window_flush <= restrict_wr_one;
			return_trim           <= restrict_wr_one && cap_large_return;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			indirect_prediction_barrier <= 1'b0;
		else
			indirect_prediction_barrier <= cmd_wr_ok && msr_wdata[scr_pkg::POS_BARRIER];
	end

	//--------------------------------------------------------------------
	// Registered control levels
	//--------------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			restrict_indirect     <= 1'b0;
			sibling_isolate       <= 1'b0;
			lower_to_higher_block <= 1'b0;
			cross_mode_block      <= 1'b0;
		end
		else
		begin
			restrict_indirect     <= field_reg[scr_pkg::IDX_RESTRICT];
			sibling_isolate       <= bus_if.eff_sibling;
			lower_to_higher_block <= bus_if.eff_lower_block;
			cross_mode_block      <= bus_if.eff_cross_block;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			store_bypass_block        <= 1'b0;
			predictive_forwarding_off <= 1'b0;
		end
		else
		begin
			store_bypass_block        <= bus_if.eff_bypass_block;
			predictive_forwarding_off <= bus_if.eff_fwd_off;
		end
	end

endmodule : scr_spec_regs

// File: bench/scr_spec_regs_properties.sv
// Concurrent checks on the speculation control register bank ports
`timescale 1ns/1ps
module scr_spec_checker
(
	input wire logic        core_clk,
	input wire logic        nrst,
	input wire logic        msr_req,
	input wire logic        msr_write,
	input wire logic [31:0] msr_addr,
	input wire logic [63:0] msr_wdata,
	input wire logic        msr_done,
	input wire logic        msr_gp_fault,
	input wire logic [63:0] msr_rdata,
	input wire logic        dispatch_hold,
	input wire logic [1:0]  current_privilege_level,
	input wire logic        guest_mode,
	input wire logic        cap_shared_pred,
	input wire logic        cap_same_mode,
	input wire logic        cap_always_on,
	input wire logic        cap_large_return,
	input wire logic        legacy_bypass_off,
	input wire logic        restrict_indirect,
	input wire logic        sibling_isolate,
	input wire logic        lower_to_higher_block,
	input wire logic        cross_mode_block,
	input wire logic        store_bypass_block,
	input wire logic        predictive_forwarding_off,
	input wire logic        indirect_window_flush,
	input wire logic        return_trim,
	input wire logic        indirect_prediction_barrier
);
	localparam logic [31:0] CA = scr_pkg::ADDR_CONTROL_REG;
	localparam logic [31:0] PA = scr_pkg::ADDR_COMMAND_REG;
	localparam logic [63:0] RM = scr_pkg::CTRL_RSVD_MASK;
	logic wr_ctl;
	assign wr_ctl = msr_req && msr_write && msr_addr == CA;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);

	chk_answer_next: assert property (msr_req && (msr_addr == CA || msr_addr == PA)
		|=> msr_done && dispatch_hold == $past(msr_write)) else $error("answer or hold wrong");
	chk_ctrl_reserved: assert property (wr_ctl && |(msr_wdata & RM)
		|=> msr_gp_fault && !indirect_window_flush) else $error("reserved write not refused");
	chk_cmd_refuse: assert property (msr_req && msr_addr == PA
		&& (!msr_write || |(msr_wdata & scr_pkg::CMD_RSVD_MASK))
		|=> msr_gp_fault && msr_rdata == 64'h0 && !indirect_prediction_barrier)
		else $error("command misuse not refused");
	chk_barrier_raise: assert property (msr_req && msr_write && msr_addr == PA
		&& msr_wdata == 64'h1 |=> indirect_prediction_barrier && !msr_gp_fault)
		else $error("barrier missing");
	chk_window_flush: assert property (wr_ctl && msr_wdata[0] && !(|(msr_wdata & RM))
		|=> indirect_window_flush && return_trim == $past(cap_large_return) ##1 restrict_indirect)
		else $error("flush or trim wrong");
	chk_read_zeros: assert property (msr_done |-> (msr_rdata & RM) == 64'h0)
		else $error("reserved read bits set");
	chk_sibling_force: assert property ($past(nrst) && restrict_indirect
		&& $past(cap_shared_pred) |-> sibling_isolate) else $error("sibling not forced");
	chk_bypass_sources: assert property ($past(nrst) && $past(nrst, 2)
		&& $past(legacy_bypass_off) |-> store_bypass_block) else $error("legacy bypass lost");
	chk_forward_off: assert property ($past(nrst) && store_bypass_block
		&& !$past(legacy_bypass_off) |-> predictive_forwarding_off) else $error("forwarding on");
	chk_mode_block: assert property ($past(nrst) && $past(nrst, 2)
		|-> lower_to_higher_block == (restrict_indirect && $past(cap_always_on)
		&& $past(current_privilege_level) != 2'h3 && !$past(guest_mode)))
		else $error("mode block wrong");
	chk_cross_mode: assert property ($past(nrst) && $past(nrst, 2)
		|-> cross_mode_block == (restrict_indirect && $past(cap_same_mode)))
		else $error("cross mode block wrong");

	cover property (indirect_prediction_barrier);
	cover property (msr_gp_fault);
	cover property (cross_mode_block && lower_to_higher_block);
endmodule : scr_spec_checker

bind scr_spec_regs scr_spec_checker chk_i (.*);

// File: bench/tb.sv
// Self-checking testbench of the speculation control register bank
`timescale 1ns/1ps
module tb;
	logic        core_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        msr_req = 1'b0;
	logic        msr_write = 1'b0;
	logic [31:0] msr_addr = 32'h0;
	logic [63:0] msr_wdata = 64'h0;
	logic [1:0]  current_privilege_level = 2'h0;
	logic        guest_mode = 1'b0;
	logic        cap_shared_pred = 1'b0;
	logic        cap_same_mode = 1'b0;
	logic        cap_always_on = 1'b0;
	logic        cap_large_return = 1'b0;
	logic        legacy_bypass_off = 1'b0;
	logic        msr_done, msr_gp_fault, dispatch_hold, restrict_indirect, sibling_isolate;
	logic        lower_to_higher_block, cross_mode_block, store_bypass_block;
	logic        predictive_forwarding_off, indirect_window_flush, return_trim;
	logic        indirect_prediction_barrier;
	logic [63:0] msr_rdata;
	wire  [2:0]  pulse_bus = {indirect_window_flush, return_trim, indirect_prediction_barrier};
	wire  [5:0]  level_bus = {restrict_indirect, sibling_isolate, lower_to_higher_block,
		cross_mode_block, store_bypass_block, predictive_forwarding_off};
	logic [7:0]  ctrl_model = 8'h0;
	int          err_total = 0;
	int          samples_checked = 0;

	scr_spec_regs dut (.*);

	always #25 core_clk = ~core_clk;

	task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// Expected level outputs from stored bits c and core state e
	function automatic logic [5:0] levels_exp(input logic [7:0] c, input logic [7:0] e);
		return {c[0], c[1] | c[0] & e[3], c[0] & e[5] & (e[1:0] != 2'h3) & !e[2],
			c[0] & e[4], c[2] | e[7], c[7] | c[2]};
	endfunction : levels_exp

	task automatic access(input logic w, input logic [31:0] a, input logic [63:0] d,
		input logic [7:0] e);
		logic       ctl;
		logic       hit;
		logic       flt;
		logic       ok;
		logic [2:0] pls;
		logic [7:0] c;
		ctl = a == scr_pkg::ADDR_CONTROL_REG;
		hit = ctl || a == scr_pkg::ADDR_COMMAND_REG;
		flt = ctl ? w && |(d & scr_pkg::CTRL_RSVD_MASK)
			: hit && (!w || |(d & scr_pkg::CMD_RSVD_MASK));
		ok = hit && w && !flt && d[0];
		pls = {ctl && ok, ctl && ok && e[6], !ctl && ok};
		c = ctrl_model;
		@(posedge core_clk);
		msr_req <= 1'b1;
		msr_write <= w;
		msr_addr <= a;
		msr_wdata <= d;
		{legacy_bypass_off, cap_large_return, cap_always_on} <= e[7:5];
		{cap_same_mode, cap_shared_pred, guest_mode, current_privilege_level} <= e[4:0];
		@(posedge core_clk);
		msr_req <= 1'b0;
		#1;
		check("done", hit, msr_done);
		check("fault", flt, msr_gp_fault);
		check("hold", w && hit, dispatch_hold);
		check("rdata", ctl && !w ? {56'h0, c} : 64'h0, msr_rdata);
		check("pulses", pls, pulse_bus);
		if (ctl && w && !flt)
			ctrl_model = d[7:0];
		c = ctrl_model;
		@(posedge core_clk);
		#1;
		check("levels", levels_exp(c, e), level_bus);
	endtask : access

	task automatic end_of_test;
		$display("Checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	initial
	begin
		logic [63:0] corner [8] = '{64'h1, 64'h1, 64'h87, 64'h8, 64'h100,
			64'h8000_0000_0000_0000, 64'h0, 64'h84};
		void'($urandom(46));
		repeat (16) @(posedge core_clk);
		nrst <= 1'b1;
		access(1'b0, scr_pkg::ADDR_CONTROL_REG, 64'h0, 8'h0);
		foreach (corner[i])
		begin
			access(1'b1, scr_pkg::ADDR_CONTROL_REG, corner[i], 8'($urandom));
			access(1'b0, scr_pkg::ADDR_CONTROL_REG, 64'h0, 8'($urandom));
		end
		// Mid-run reset clears the stored bits
		nrst <= 1'b0;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		ctrl_model = 8'h0;
		access(1'b0, scr_pkg::ADDR_CONTROL_REG, 64'h0, 8'h0);
		access(1'b0, scr_pkg::ADDR_COMMAND_REG, 64'h0, 8'h0);
		access(1'b1, scr_pkg::ADDR_COMMAND_REG, 64'h2, 8'h0);
		access(1'b1, scr_pkg::ADDR_COMMAND_REG, 64'h1, 8'h0);
		access(1'b1, 32'h0000_004A, 64'h1, 8'h0);
		repeat (150)
			access(1'($urandom), 32'h48 + 32'($urandom % 3), $urandom % 2 ?
				{$urandom, $urandom} : 64'($urandom % 256), 8'($urandom));
		end_of_test();
	end

	initial
	begin
		repeat (2000) @(posedge core_clk);
		err_total++;
		end_of_test();
	end
endmodule : tb
